/* File: pdm_pkg.sv */
`default_nettype none
package pdm_pkg;
   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [11:0] ADDR_CH1_READ_WAIT_CYCLES = 12'h820;
   localparam logic [11:0] ADDR_CH1_READ_MAX_LATENCY = 12'h824;
   localparam logic [11:0] ADDR_CH1_WRITE_DATA_CYCLES = 12'h828;
   localparam logic [11:0] ADDR_CH1_WRITE_STALL_CYCLES = 12'h82c;
   localparam logic [11:0] ADDR_CH1_WRITE_MAX_LATENCY = 12'h830;
   localparam logic [11:0] ADDR_MODULE_IDENTIFICATION = 12'h834;
   localparam logic [11:0] ADDR_MONITOR_CONTROL = 12'h808;
   localparam logic [11:0] ADDR_SOURCE_SELECT_BASE = 12'h900;
   // ---------------------------------------------------------------
   // Fields and values
   // ---------------------------------------------------------------
   localparam int MONITOR1_CLEAR_BIT = 1;
   localparam int VERSION_LSB = 0;
   localparam int VARIANT_LSB = 16;
   localparam logic [11:0] VERSION_VALUE = 12'h5a5; // Arbitrary value
   localparam logic [3:0] VARIANT_VALUE = 4'h0; // Arbitrary value
   localparam int NUM_CHANNELS = 12;
   localparam int NUM_MONITORS = 1;
   localparam int PERIPH_ID_W = 5;
   localparam logic [4:0] PERIPH_ID_FIRST_TX = 5'h0c;
   localparam logic [4:0] PERIPH_ID_LAST = 5'h16;
   localparam logic [31:0] RESET_VALUE = 32'h0;
   // ---------------------------------------------------------------
   // Monitor event bundle
   // ---------------------------------------------------------------
   typedef struct packed {
      logic start;
      logic beat;
      logic wait_st;
   } pdm_evt_t;
endpackage
`default_nettype wire

/* File: pdm_sat_counter.sv */
`timescale 1ns/10ps
`default_nettype none
module pdm_sat_counter #(
   parameter int WIDTH = 16
) (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_clear,
   input wire logic i_evt,
   output logic [WIDTH-1:0] o_count
);
   initial begin
      if (WIDTH < 1 || WIDTH > 32) begin
         $error("pdm_sat_counter width out of range");
      end
   end
   // Saturate instead of wrapping, clear has priority
   always_ff @(posedge i_mclk) begin
      if (!i_nrst || i_clear) begin
         o_count <= '0;
      end else if (i_evt && o_count != {WIDTH{1'b1}}) begin
         o_count <= o_count + 1'b1;
      end
   end
endmodule
`default_nettype wire

/* File: pdm_latency_tracker.sv */
`timescale 1ns/10ps
`default_nettype none
module pdm_latency_tracker #(
   parameter int WIDTH = 16
) (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_clear,
   input wire pdm_pkg::pdm_evt_t i_evt,
   output logic [WIDTH-1:0] o_max
);
   logic [WIDTH-1:0] run;
   logic busy;
   logic [WIDTH-1:0] next_run;
   initial begin
      if (WIDTH < 1 || WIDTH > 32) begin
         $error("pdm_latency_tracker width out of range");
      end
   end
   // Running latency from request to first beat, saturating
   always_comb begin
      next_run = run;
      if (run != {WIDTH{1'b1}}) begin
         next_run = run + 1'b1;
      end
   end
   always_ff @(posedge i_mclk) begin
      if (!i_nrst || i_clear) begin
         busy <= 1'b0;
         run <= '0;
      end else if (i_evt.beat) begin
         busy <= 1'b0;
         run <= '0;
      end else if (i_evt.start || busy) begin
         busy <= 1'b1;
         run <= next_run;
      end
   end
   // Maximum held until cleared
   always_ff @(posedge i_mclk) begin
      if (!i_nrst || i_clear) begin
         o_max <= '0;
      end else if (i_evt.beat && (busy || i_evt.start) && run > o_max) begin
         o_max <= run;
      end
   end
endmodule
`default_nettype wire

/* File: pdm_monitor.sv */
// Operation
// - Channel 1 keeps 16-bit read and write maximum initiation latencies, upper bits reading zero.
// - All monitor counts advance on the high-speed bus clock.
// - Latency maxima saturate at all ones instead of wrapping.
// - Channel 1 values clear only when software writes one to the monitor-1 clear bit.
// - A read-only 32-bit write data-cycle count accumulates from the last clear and resets to zero.
// - Read-only 32-bit read and write stall counts accumulate from the last clear.
// - The identification register shows a 12-bit version in bits 11 to 0.
// - A 4-bit variant field sits in bits 19 to 16 with no function.
// - The controller has 12 channels and one performance monitor.
// - Monitor counters and registers both run on the single bus clock, with no register bus clock.
// - Each peripheral identifier has its own request and acknowledge handshake pair.
// - Each channel source select holds a peripheral identifier and resets to its channel number.
// - Identifiers 0 to 11 are receive, 12 to 22 are transmit.
`timescale 1ns/10ps
`default_nettype none
module pdm_monitor #(
   parameter int NUM_CH = pdm_pkg::NUM_CHANNELS,
   parameter int LATENCY_W = 16,
   parameter int NUM_PERIPH_ID = 23
) (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic [11:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire pdm_pkg::pdm_evt_t i_rd_evt,
   input wire pdm_pkg::pdm_evt_t i_wr_evt,
   input wire logic [NUM_PERIPH_ID-1:0] i_periph_req,
   output logic [NUM_PERIPH_ID-1:0] o_periph_ack,
   output logic [NUM_CH-1:0] o_ch_is_tx,
   output logic [NUM_CH-1:0] o_ch_req
);
   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   initial begin
      if (NUM_CH != pdm_pkg::NUM_CHANNELS || pdm_pkg::NUM_MONITORS != 1) begin
         $error("pdm_monitor channel configuration unsupported");
      end
      if (LATENCY_W != 16 || NUM_PERIPH_ID > 32 || NUM_PERIPH_ID < 1) begin
         $error("pdm_monitor width unsupported");
      end
      // Receive identifiers are one per channel, transmit ones follow
      if (int'(pdm_pkg::PERIPH_ID_FIRST_TX) != NUM_CH) begin
         $error("pdm_monitor receive range does not match channels");
      end
      if (int'(pdm_pkg::PERIPH_ID_LAST) + 1 != NUM_PERIPH_ID) begin
         $error("pdm_monitor identifier count does not match");
      end
      // Reset identifier of every channel must fit the select field
      if (NUM_CH > (1 << pdm_pkg::PERIPH_ID_W)) begin
         $error("pdm_monitor select field too narrow");
      end
      if (NUM_PERIPH_ID > (1 << pdm_pkg::PERIPH_ID_W)) begin
         $error("pdm_monitor identifier field too narrow");
      end
   end

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   logic [31:0] write_data_cycles;
   logic [31:0] write_stall_cycles;
   logic [31:0] read_wait_cycles;
   logic [LATENCY_W-1:0] read_max;
   logic [LATENCY_W-1:0] write_max;
   logic [pdm_pkg::PERIPH_ID_W-1:0] src_sel [NUM_CH];
   logic [NUM_CH-1:0] sel_addr;
   logic [31:0] next_rdata;
   logic rd_wait;
   logic wr_wait;

   // ---------------------------------------------------------------
   // Register decode
   // ---------------------------------------------------------------
   logic hit_control;
   logic hit_read_wait;
   logic hit_read_max;
   logic hit_write_data;
   logic hit_write_stall;
   logic hit_write_max;
   logic hit_ident;
   logic clear1;
   // Full compare, so no register shows up at a second address
   always_comb begin
      hit_control = i_addr == pdm_pkg::ADDR_MONITOR_CONTROL;
      hit_read_wait = i_addr == pdm_pkg::ADDR_CH1_READ_WAIT_CYCLES;
      hit_read_max = i_addr == pdm_pkg::ADDR_CH1_READ_MAX_LATENCY;
      hit_write_data = i_addr == pdm_pkg::ADDR_CH1_WRITE_DATA_CYCLES;
      hit_write_stall = i_addr == pdm_pkg::ADDR_CH1_WRITE_STALL_CYCLES;
      hit_write_max = i_addr == pdm_pkg::ADDR_CH1_WRITE_MAX_LATENCY;
      hit_ident = i_addr == pdm_pkg::ADDR_MODULE_IDENTIFICATION;
   end

   // Only the clear bit of the control word has an effect
   // Writes to count and latency words are dropped, so nothing else clears them
   assign clear1 = i_wr && hit_control && i_wdata[pdm_pkg::MONITOR1_CLEAR_BIT];

   // ---------------------------------------------------------------
   // Monitor counters, all on the bus clock
   // ---------------------------------------------------------------
   // Stall means a transfer is open and no beat landed this cycle
   assign rd_wait = i_rd_evt.wait_st && !i_rd_evt.beat;
   assign wr_wait = i_wr_evt.wait_st && !i_wr_evt.beat;

   pdm_sat_counter #(.WIDTH(32)) u_wdata (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_clear(clear1),
      .i_evt(i_wr_evt.beat),
      .o_count(write_data_cycles)
   );
   pdm_sat_counter #(.WIDTH(32)) u_wstall (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_clear(clear1),
      .i_evt(wr_wait),
      .o_count(write_stall_cycles)
   );
   pdm_sat_counter #(.WIDTH(32)) u_rstall (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_clear(clear1),
      .i_evt(rd_wait),
      .o_count(read_wait_cycles)
   );
   pdm_latency_tracker #(.WIDTH(LATENCY_W)) u_rlat (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_clear(clear1),
      .i_evt(i_rd_evt),
      .o_max(read_max)
   );
   pdm_latency_tracker #(.WIDTH(LATENCY_W)) u_wlat (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_clear(clear1),
      .i_evt(i_wr_evt),
      .o_max(write_max)
   );

   // ---------------------------------------------------------------
   // Source select per channel
   // ---------------------------------------------------------------
   // Single clock: the register side shares the bus clock, so no crossing is needed
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : gen_ch
         logic hit;
         assign sel_addr[g] = i_addr == pdm_pkg::ADDR_SOURCE_SELECT_BASE + 12'(4 * g);
         assign hit = i_wr && sel_addr[g];
         // Out-of-range identifiers are dropped so a channel never selects nothing
         always_ff @(posedge i_mclk) begin
            if (!i_nrst) begin
               src_sel[g] <= pdm_pkg::PERIPH_ID_W'(g);
            end else if (hit && i_wdata[pdm_pkg::PERIPH_ID_W-1:0] <= pdm_pkg::PERIPH_ID_LAST) begin
               src_sel[g] <= i_wdata[pdm_pkg::PERIPH_ID_W-1:0];
            end
         end
         // Direction follows the identifier range
         always_ff @(posedge i_mclk) begin
            if (!i_nrst) begin
               o_ch_is_tx[g] <= 1'b0;
            end else begin
               o_ch_is_tx[g] <= src_sel[g] >= pdm_pkg::PERIPH_ID_FIRST_TX;
            end
         end
         // Request of the selected identifier, seen one cycle late
         always_ff @(posedge i_mclk) begin
            if (!i_nrst) begin
               o_ch_req[g] <= 1'b0;
            end else begin
               o_ch_req[g] <= i_periph_req[src_sel[g]];
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Handshake acknowledge back to each identifier
   // ---------------------------------------------------------------
   logic [NUM_PERIPH_ID-1:0] owned;
   logic [NUM_PERIPH_ID-1:0] next_ack;
   // An identifier is owned when a channel selects it and saw its request
   always_comb begin
      owned = '0;
      for (int c = 0; c < NUM_CH; c++) begin
         if (o_ch_req[c] && int'(src_sel[c]) < NUM_PERIPH_ID) begin
            owned[src_sel[c]] = 1'b1;
         end
      end
   end
   // Channel view lags the pin, so the request must still stand at the pin
   // Alternate cycles give the partner time to drop a served request
   assign next_ack = owned & i_periph_req & ~o_periph_ack;
   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         o_periph_ack <= '0;
      end else begin
         o_periph_ack <= next_ack;
      end
   end

   // ---------------------------------------------------------------
   // Read mux, data in the cycle after the strobe
   // ---------------------------------------------------------------
   // Unmapped and write-only words read as zero
   always_comb begin
      next_rdata = pdm_pkg::RESET_VALUE;
      if (hit_read_wait) begin
         next_rdata = read_wait_cycles;
      end else if (hit_read_max) begin
         next_rdata[LATENCY_W-1:0] = read_max;
      end else if (hit_write_data) begin
         next_rdata = write_data_cycles;
      end else if (hit_write_stall) begin
         next_rdata = write_stall_cycles;
      end else if (hit_write_max) begin
         next_rdata[LATENCY_W-1:0] = write_max;
      end else if (hit_ident) begin
         next_rdata[pdm_pkg::VERSION_LSB +: 12] = pdm_pkg::VERSION_VALUE;
         next_rdata[pdm_pkg::VARIANT_LSB +: 4] = pdm_pkg::VARIANT_VALUE;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (sel_addr[c]) begin
               next_rdata[pdm_pkg::PERIPH_ID_W-1:0] = src_sel[c];
            end
         end
      end
   end
   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         o_rdata <= '0;
      end else if (i_rd) begin
         o_rdata <= next_rdata;
      end else begin
         o_rdata <= '0;
      end
   end
endmodule
`default_nettype wire

/* File: pdm_check_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module pdm_check #(
   parameter int NUM_CH = 12,
   parameter int NUM_PERIPH_ID = 23
) (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic [11:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic [NUM_PERIPH_ID-1:0] i_periph_req,
   input wire logic [NUM_PERIPH_ID-1:0] o_periph_ack,
   input wire logic [NUM_CH-1:0] o_ch_is_tx
);
   // ---------------------------------------------------------------
   // Port relations
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);
   sequence s_clear;
      i_wr && i_addr == pdm_pkg::ADDR_MONITOR_CONTROL && i_wdata[pdm_pkg::MONITOR1_CLEAR_BIT];
   endsequence
   sequence s_rd_data;
      i_rd && i_addr == pdm_pkg::ADDR_CH1_WRITE_DATA_CYCLES;
   endsequence
   a_clear_then_zero: assert property (s_clear ##1 s_rd_data |=> o_rdata == 32'h0)
      else $error("count not zero after clear");
   a_version_field: assert property (i_rd && i_addr == 12'h834 |=> o_rdata[15:0] == {4'h0, pdm_pkg::VERSION_VALUE})
      else $error("version field wrong");
   a_variant_field: assert property (i_rd && i_addr == 12'h834 |=> o_rdata[31:16] == {12'h0, pdm_pkg::VARIANT_VALUE})
      else $error("variant field wrong");
   a_latency_upper_zero: assert property (i_rd && (i_addr == 12'h824 || i_addr == 12'h830) |=> o_rdata[31:16] == 16'h0)
      else $error("latency upper bits set");
   a_unmapped_zero: assert property (i_rd && i_addr == 12'h800 |=> o_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_rx_after_reset: assert property ($rose(i_nrst) |-> o_ch_is_tx == '0)
      else $error("channel direction after reset");
   a_tx_map: assert property (i_wr && i_addr == 12'h900 && i_wdata[4:0] <= pdm_pkg::PERIPH_ID_LAST
      |-> ##2 o_ch_is_tx[0] == ($past(i_wdata[4:0], 2) >= pdm_pkg::PERIPH_ID_FIRST_TX))
      else $error("direction of identifier wrong");
   a_ack_needs_req: assert property ((o_periph_ack & ~$past(i_periph_req)) == '0)
      else $error("ack without request");
   a_ack_alternates: assert property (|o_periph_ack |-> (o_periph_ack & $past(o_periph_ack)) == '0)
      else $error("ack on consecutive cycles");
endmodule
bind pdm_monitor pdm_check #(.NUM_CH(NUM_CH), .NUM_PERIPH_ID(NUM_PERIPH_ID)) u_chk (.i_mclk(i_mclk), .i_nrst(i_nrst),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .i_periph_req(i_periph_req), .o_periph_ack(o_periph_ack), .o_ch_is_tx(o_ch_is_tx));
`default_nettype wire

/* File: pdm_periph.sv */
`timescale 1ns/10ps
`default_nettype none
module pdm_periph (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic [22:0] i_want,
   input wire logic [22:0] i_ack,
   output logic [22:0] o_req
);
   // ---------------------------------------------------------------
   // Request held until acknowledged
   // ---------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         o_req <= 23'h0;
      end else begin
         o_req <= (o_req | i_want) & ~i_ack;
      end
   end
endmodule
`default_nettype wire

/* File: pdm_monitor_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin $display("FAIL %s exp %h got %h", n, e, g); mismatches++; end end
module pdm_monitor_tb_top;
   logic i_mclk = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0, seen = 1'b0;
   logic [11:0] i_addr = 12'h0, is_tx, ch_req;
   logic [31:0] i_wdata = 32'h0, rdata;
   logic [22:0] want = 23'h0, req, ack;
   pdm_pkg::pdm_evt_t ev = '0;
   logic [11:0] regs [4] = '{12'h820, 12'h824, 12'h82c, 12'h830};
   logic [4:0] pids [3] = '{5'h0b, 5'h0c, 5'h16};
   int mismatches = 0, total_checks = 0;
   always #20 i_mclk = ~i_mclk;
   pdm_monitor dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(rdata), .i_rd_evt(ev), .i_wr_evt(ev), .i_periph_req(req),
      .o_periph_ack(ack), .o_ch_is_tx(is_tx), .o_ch_req(ch_req));
   pdm_periph u_per (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_want(want), .i_ack(ack), .o_req(req));
   // ---------------------------------------------------------------
   // Bus and event tasks
   // ---------------------------------------------------------------
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input bit hold = 1'b0);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      if (!hold) begin
         @(posedge i_mclk);
         i_wr <= 1'b0;
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge i_mclk);
      i_wr <= 1'b0;
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 `CHK($sformatf("reg %h", a), e, rdata)
   endtask
   // Start cycle, n waiting cycles in all, then the completing beat
   task automatic burst(input int n);
      @(posedge i_mclk) ev <= 3'b101;
      repeat (n - 1) @(posedge i_mclk) ev <= 3'b001;
      @(posedge i_mclk) ev <= 3'b011;
      @(posedge i_mclk) ev <= 3'b000;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      // Saturation run dominates the budget
      repeat (90000) @(posedge i_mclk);
      mismatches++;
      tally_and_finish();
   end
   initial begin
      repeat (20) @(posedge i_mclk);
      i_nrst <= 1'b1;
      for (int n = 0; n < 12; n++) rd(12'h900 + 12'(4 * n), 32'(n));
      #1 `CHK("is_tx", 12'h0, is_tx)
      foreach (regs[i]) rd(regs[i], 32'h0);
      rd(12'h828, 32'h0);
      burst(3);
      burst(1);
      rd(12'h820, 32'h4);
      rd(12'h824, 32'h3);
      rd(12'h828, 32'h2);
      rd(12'h82c, 32'h4);
      rd(12'h830, 32'h3);
      wr(12'h828, 32'h55);
      rd(12'h828, 32'h2);
      wr(12'h808, 32'h1);
      rd(12'h828, 32'h2);
      rd(12'h834, {12'h0, pdm_pkg::VARIANT_VALUE, 4'h0, pdm_pkg::VERSION_VALUE});
      rd(12'h800, 32'h0);
      wr(12'h808, 32'h2, 1'b1);
      rd(12'h828, 32'h0);
      foreach (regs[i]) rd(regs[i], 32'h0);
      foreach (pids[i]) begin
         wr(12'h900, {27'h0, pids[i]});
         repeat (2) @(posedge i_mclk);
         #1 `CHK("is_tx0", pids[i] >= 5'h0c, is_tx[0])
      end
      wr(12'h900, 32'h17);
      rd(12'h900, 32'h16);
      @(posedge i_mclk) want <= 23'h2;
      @(posedge i_mclk) want <= 23'h0;
      repeat (10) @(posedge i_mclk) seen <= seen | (ch_req[1] & ack[1]);
      #1 `CHK("handshake", 1'b1, seen)
      `CHK("req_dropped", 23'h0, req)
      burst(65540);
      rd(12'h824, 32'hffff);
      rd(12'h830, 32'hffff);
      tally_and_finish();
   end
endmodule
`default_nettype wire
